/* core/timer_pair_input_capture.sv */
// Timer pair control (two 16-bit timers, optionally one 32-bit timer) and one
// input capture channel with a four word buffer, behind an APB slave.
// Assumes IDLE_I and SLEEP_I come from logic on CLK_SYS_I; pins are asynchronous.
`include "timer_pair_input_capture_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module timer_pair_input_capture #(
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_N_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic [1:0]  EXTERNAL_TIMER_CLOCK_PIN_I,
   input  wire logic        CAPTURE_INPUT_PIN_I,
   input  wire logic        IDLE_I,
   input  wire logic        SLEEP_I,
   output logic             CAPTURE_IRQ_O,
   output logic             WAKE_O,
   output logic             ADC_TRIGGER_O
);

   localparam int PTR_W = $clog2(FIFO_DEPTH);
   localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(FIFO_DEPTH);

   // Buffer pointers wrap naturally only for powers of two
   if (FIFO_DEPTH != 4) begin : g_depth_check
      $error("FIFO_DEPTH must be 4");
   end

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   timer_pair_input_capture_pkg::timer_ctrl_type   tctl_reg [2];
   timer_pair_input_capture_pkg::capture_ctrl_type cctl_reg;
   logic [15:0]      tmr_reg [2];
   logic [7:0]       pre_reg [2];
   logic [2:0]       sync_reg [3];
   logic [2:0]       filt_reg, filt_prev_reg, rise, fall;
   logic [15:0]      fifo_mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [PTR_W:0]   count_reg;
   logic [3:0]       edge_cnt_reg;
   logic [1:0]       irq_cnt_reg;
   logic [31:0]      prdata_reg, rd_word;
   logic             ovf_reg, pready_reg, pslverr_reg, pop_armed_reg, irq_reg, wake_reg, adc_reg;
   logic             apb_access, wr_en, rd_done, mapped, lower_wrap;
   logic             cap_event, cap_take, push, pop, pin_irq_mode;
   logic [1:0]       src_tick, active, inc;
   logic [7:0]       div_lim [2];
   logic [15:0]      cap_value;

   // -------------------------------------------------------------------------
   // Pin synchronisers: three stages, change accepted when 2nd and 3rd agree
   // -------------------------------------------------------------------------
   logic [2:0] pin_vec;
   assign pin_vec = {CAPTURE_INPUT_PIN_I, EXTERNAL_TIMER_CLOCK_PIN_I};

   for (genvar p = 0; p < 3; p++) begin : g_sync
      // First stage feeds only the second stage
      always_ff @(posedge CLK_SYS_I) begin
         if (!RST_N_I) begin
            sync_reg[p]      <= 3'b000;
            filt_reg[p]      <= 1'b0;
            filt_prev_reg[p] <= 1'b0;
         end else begin
            sync_reg[p]      <= {sync_reg[p][1:0], pin_vec[p]};
            filt_prev_reg[p] <= filt_reg[p];
            if (sync_reg[p][1] == sync_reg[p][2]) begin
               filt_reg[p] <= sync_reg[p][2];
            end
         end
      end
      assign rise[p] = filt_reg[p] & ~filt_prev_reg[p];
      assign fall[p] = ~filt_reg[p] & filt_prev_reg[p];
   end

   // -------------------------------------------------------------------------
   // APB slave: one wait state, answer registered
   // -------------------------------------------------------------------------
   assign apb_access = PSEL_I & PENABLE_I;
   assign wr_en      = apb_access & pready_reg & PWRITE_I;
   assign rd_done    = apb_access & pready_reg & ~PWRITE_I;

   // Read mux and address decode
   always_comb begin
      rd_word = 32'h0000_0000;
      mapped  = 1'b1;
      case (PADDR_I)
         `ADDR_LOWER_CTRL, `ADDR_UPPER_CTRL: begin
            rd_word[`TBIT_RUN]                = tctl_reg[PADDR_I[2]].timer_run_enable;
            rd_word[`TBIT_IDLE]               = tctl_reg[PADDR_I[2]].timer_idle_halt;
            rd_word[`TBIT_GATE]               = tctl_reg[PADDR_I[2]].gate_accumulate_enable;
            rd_word[`TBIT_DIV_HI:`TBIT_DIV_LO] = tctl_reg[PADDR_I[2]].clock_divide_select;
            rd_word[`TBIT_PAIR]               = tctl_reg[PADDR_I[2]].pair_mode_select;
            rd_word[`TBIT_SRC]                = tctl_reg[PADDR_I[2]].clock_source_select;
         end
         `ADDR_CAPTURE_CTRL: begin
            rd_word[`CBIT_IDLE]                = cctl_reg.capture_idle_halt;
            rd_word[`CBIT_TSEL]                = cctl_reg.capture_timebase_select;
            rd_word[`CBIT_IRQ_HI:`CBIT_IRQ_LO] = cctl_reg.captures_per_interrupt;
            rd_word[`CBIT_OVF]                 = ovf_reg;
            rd_word[`CBIT_BNE]                 = (count_reg != '0);
            rd_word[`CBIT_MODE_HI:0]           = cctl_reg.capture_mode_select;
         end
         `ADDR_CAPTURE_BUF: rd_word[15:0] = (count_reg != '0) ? fifo_mem[rd_ptr_reg] : 16'h0000;
         `ADDR_LOWER_COUNT: rd_word[15:0] = tmr_reg[0];
         `ADDR_UPPER_COUNT: rd_word[15:0] = tmr_reg[1];
         default: mapped = 1'b0;
      endcase
   end

   // Answer one cycle into the access phase
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         pready_reg    <= 1'b0;
         prdata_reg    <= 32'h0000_0000;
         pslverr_reg   <= 1'b0;
         pop_armed_reg <= 1'b0;
      end else begin
         pready_reg <= apb_access & ~pready_reg;
         if (apb_access & ~pready_reg) begin
            prdata_reg    <= PWRITE_I ? 32'h0000_0000 : rd_word;
            pslverr_reg   <= ~mapped;
            // Pop only the entry actually returned; guards a push racing an empty read
            pop_armed_reg <= ~PWRITE_I & (PADDR_I == `ADDR_CAPTURE_BUF) & (count_reg != '0);
         end
      end
   end

   // Control register writes, only implemented bits stored
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         tctl_reg[0] <= '0;
         tctl_reg[1] <= '0;
         cctl_reg    <= '0;
      end else if (wr_en) begin
         if (PADDR_I == `ADDR_LOWER_CTRL || PADDR_I == `ADDR_UPPER_CTRL) begin
            tctl_reg[PADDR_I[2]].timer_run_enable       <= PWDATA_I[`TBIT_RUN];
            tctl_reg[PADDR_I[2]].timer_idle_halt        <= PWDATA_I[`TBIT_IDLE];
            tctl_reg[PADDR_I[2]].gate_accumulate_enable <= PWDATA_I[`TBIT_GATE];
            tctl_reg[PADDR_I[2]].clock_divide_select    <= PWDATA_I[`TBIT_DIV_HI:`TBIT_DIV_LO];
            // Pair bit lives in the lower register only
            tctl_reg[PADDR_I[2]].pair_mode_select       <= PWDATA_I[`TBIT_PAIR] & ~PADDR_I[2];
            tctl_reg[PADDR_I[2]].clock_source_select    <= PWDATA_I[`TBIT_SRC];
         end
         if (PADDR_I == `ADDR_CAPTURE_CTRL) begin
            cctl_reg.capture_idle_halt       <= PWDATA_I[`CBIT_IDLE];
            cctl_reg.capture_timebase_select <= PWDATA_I[`CBIT_TSEL];
            cctl_reg.captures_per_interrupt  <= PWDATA_I[`CBIT_IRQ_HI:`CBIT_IRQ_LO];
            cctl_reg.capture_mode_select     <=
               timer_pair_input_capture_pkg::capture_mode_type'(PWDATA_I[`CBIT_MODE_HI:0]);
         end
      end
   end

   // -------------------------------------------------------------------------
   // Timer tick sources, idle halting and prescalers
   // -------------------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         // External pin wins; gate pin level only counts on internal clock
         src_tick[i] = tctl_reg[i].clock_source_select ? rise[i]
                     : (tctl_reg[i].gate_accumulate_enable ? filt_reg[i] : 1'b1);
         case (tctl_reg[i].clock_divide_select)
            2'b11:   div_lim[i] = `DIV_LIM_256;
            2'b10:   div_lim[i] = `DIV_LIM_64;
            2'b01:   div_lim[i] = `DIV_LIM_8;
            default: div_lim[i] = `DIV_LIM_1;
         endcase
      end
      // In pair mode the upper idle bit still halts the pair
      active[0] = tctl_reg[0].timer_run_enable & ~(IDLE_I & (tctl_reg[0].timer_idle_halt
                  | (tctl_reg[0].pair_mode_select & tctl_reg[1].timer_idle_halt)));
      // Upper controls other than the idle-halt bit are ignored while paired
      active[1] = tctl_reg[1].timer_run_enable & ~(IDLE_I & tctl_reg[1].timer_idle_halt)
                  & ~tctl_reg[0].pair_mode_select;
      for (int i = 0; i < 2; i++) begin
         inc[i] = active[i] & src_tick[i] & (pre_reg[i] == div_lim[i]);
      end
   end

   // Prescale counters restart whenever their timer is stopped
   always_ff @(posedge CLK_SYS_I) begin
      for (int i = 0; i < 2; i++) begin
         if (!RST_N_I || !active[i]) begin
            pre_reg[i] <= 8'h00;
         end else if (src_tick[i]) begin
            pre_reg[i] <= (pre_reg[i] == div_lim[i]) ? 8'h00 : pre_reg[i] + 8'h01;
         end
      end
   end

   assign lower_wrap = inc[0] & (tmr_reg[0] == `COUNT_MAX);

   // Counters; a bus write overrides counting
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         tmr_reg[0] <= `RESET_WORD;
         tmr_reg[1] <= `RESET_WORD;
      end else begin
         if (wr_en && PADDR_I == `ADDR_LOWER_COUNT) begin
            tmr_reg[0] <= PWDATA_I[15:0];
         end else if (inc[0]) begin
            tmr_reg[0] <= tmr_reg[0] + 16'h0001;
         end
         if (wr_en && PADDR_I == `ADDR_UPPER_COUNT) begin
            tmr_reg[1] <= PWDATA_I[15:0];
         end else if (tctl_reg[0].pair_mode_select ? lower_wrap : inc[1]) begin
            tmr_reg[1] <= tmr_reg[1] + 16'h0001;
         end
      end
   end

   // Converter trigger on 32-bit rollover; single timers never trigger
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         adc_reg <= 1'b0;
      end else begin
         adc_reg <= tctl_reg[0].pair_mode_select & lower_wrap & (tmr_reg[1] == `COUNT_MAX);
      end
   end

   // -------------------------------------------------------------------------
   // Capture event qualification
   // -------------------------------------------------------------------------
   assign pin_irq_mode = (cctl_reg.capture_mode_select == timer_pair_input_capture_pkg::CAP_WAKE_ONLY);

   always_comb begin
      case (cctl_reg.capture_mode_select)
         timer_pair_input_capture_pkg::CAP_EVERY_EDGE: cap_event = rise[2] | fall[2];
         timer_pair_input_capture_pkg::CAP_FALL:       cap_event = fall[2];
         timer_pair_input_capture_pkg::CAP_RISE:       cap_event = rise[2];
         timer_pair_input_capture_pkg::CAP_RISE_4:     cap_event = rise[2] & (edge_cnt_reg[1:0] == 2'b11);
         timer_pair_input_capture_pkg::CAP_RISE_16:    cap_event = rise[2] & (edge_cnt_reg == 4'hF);
         default:                                      cap_event = 1'b0;
      endcase
      cap_take  = cap_event & ~(IDLE_I & cctl_reg.capture_idle_halt);
      cap_value = cctl_reg.capture_timebase_select ? tmr_reg[0] : tmr_reg[1];
      push      = cap_take & (count_reg != FULL_COUNT);
      pop       = rd_done & pop_armed_reg;
   end

   // Rising edge prescaler, cleared outside the prescaled modes
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I || cctl_reg.capture_mode_select[2:1] != 2'b10) begin
         edge_cnt_reg <= 4'h0;
      end else if (rise[2] && !(IDLE_I && cctl_reg.capture_idle_halt)) begin
         edge_cnt_reg <= edge_cnt_reg + 4'h1;
      end
   end

   // -------------------------------------------------------------------------
   // Capture buffer and overflow
   // -------------------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I) begin
      if (push) begin
         fifo_mem[wr_ptr_reg] <= cap_value;
      end
   end

   // Disabling the channel flushes it
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I || cctl_reg.capture_mode_select == timer_pair_input_capture_pkg::CAP_OFF) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + PTR_W'(push);
         rd_ptr_reg <= rd_ptr_reg + PTR_W'(pop);
         count_reg  <= count_reg + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
      end
   end

   // Overflow set on a dropped capture; cleared when a read empties the buffer
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         ovf_reg <= 1'b0;
      end else if (cap_take && count_reg == FULL_COUNT) begin
         ovf_reg <= 1'b1;
      end else if ((pop && count_reg == 1) ||
                   cctl_reg.capture_mode_select == timer_pair_input_capture_pkg::CAP_OFF) begin
         ovf_reg <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Capture interrupt and wake
   // -------------------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I || cctl_reg.capture_mode_select == timer_pair_input_capture_pkg::CAP_OFF) begin
         irq_cnt_reg <= 2'b00;
         irq_reg     <= 1'b0;
         wake_reg    <= 1'b0;
      end else begin
         irq_reg  <= 1'b0;
         wake_reg <= 1'b0;
         if (pin_irq_mode) begin
            // Pin acts as a wake source only while asleep or idle
            irq_reg  <= rise[2] & (SLEEP_I | IDLE_I);
            wake_reg <= rise[2] & (SLEEP_I | IDLE_I);
         end else if (cap_take) begin
            if (cctl_reg.capture_mode_select == timer_pair_input_capture_pkg::CAP_EVERY_EDGE) begin
               irq_reg     <= 1'b1;
               irq_cnt_reg <= 2'b00;
            end else if (irq_cnt_reg == cctl_reg.captures_per_interrupt) begin
               irq_reg     <= 1'b1;
               irq_cnt_reg <= 2'b00;
            end else begin
               irq_cnt_reg <= irq_cnt_reg + 2'b01;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign PRDATA_O      = prdata_reg;
   assign PREADY_O      = pready_reg;
   assign PSLVERR_O     = pslverr_reg;
   assign CAPTURE_IRQ_O = irq_reg;
   assign WAKE_O        = wake_reg;
   assign ADC_TRIGGER_O = adc_reg;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);

   a_fifo_depth_bound: assert property (count_reg <= FULL_COUNT)
      else $error("capture buffer count above depth");
   a_overflow_on_full: assert property (cap_take && count_reg == FULL_COUNT && !pop
                                        |=> ovf_reg && count_reg == FULL_COUNT)
      else $error("full buffer capture not flagged or not dropped");
   a_overflow_sticky: assert property (ovf_reg && !pop && cctl_reg.capture_mode_select != 3'b000 |=> ovf_reg)
      else $error("overflow flag cleared without buffer drain");
   a_disabled_no_capture: assert property (cctl_reg.capture_mode_select inside {3'b000, 3'b110, 3'b111}
                                           |-> !cap_take)
      else $error("capture taken in disabled mode");
   a_capture_value_latched: assert property (push |=> fifo_mem[$past(wr_ptr_reg)] == $past(cap_value))
      else $error("captured word differs from selected timer");
   a_bne_tracks_count: assert property (push && count_reg == 0
                                        |=> rd_word[`CBIT_BNE] || PADDR_I != `ADDR_CAPTURE_CTRL)
      else $error("buffer-not-empty low after a capture");
   a_idle_halts_lower: assert property (IDLE_I && tctl_reg[0].timer_idle_halt && !wr_en |=> $stable(tmr_reg[0]))
      else $error("lower timer counted while idle halted");
   a_stopped_upper: assert property (!tctl_reg[0].pair_mode_select && !tctl_reg[1].timer_run_enable && !wr_en
                                     |=> $stable(tmr_reg[1]))
      else $error("stopped upper timer counted");
   a_trigger_pair_only: assert property (ADC_TRIGGER_O |-> $past(tctl_reg[0].pair_mode_select))
      else $error("converter trigger from a 16-bit timer");
   a_every_edge_irq: assert property (cap_take && cctl_reg.capture_mode_select == 3'b001 |=> CAPTURE_IRQ_O)
      else $error("every-edge capture without interrupt");
   a_read_answer: assert property (apb_access && !pready_reg |=> pready_reg)
      else $error("APB answer not given after one wait state");

   c_capture_push: cover property (push);
   c_overflow: cover property (cap_take && count_reg == FULL_COUNT);
   c_pair_trigger: cover property (ADC_TRIGGER_O);
   c_wake: cover property (WAKE_O);

endmodule

`default_nettype wire

/* common/timer_pair_input_capture_defs.svh */
// Offsets, field positions, reset values and divider counts of the timer pair
// and input capture block. Assumes a 32-bit APB with byte addresses.
`ifndef TIMER_PAIR_INPUT_CAPTURE_DEFS_SVH
`define TIMER_PAIR_INPUT_CAPTURE_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ADDR_LOWER_CTRL   8'h00
`define ADDR_UPPER_CTRL   8'h04
`define ADDR_CAPTURE_CTRL 8'h08
`define ADDR_CAPTURE_BUF  8'h0C
`define ADDR_LOWER_COUNT  8'h10
`define ADDR_UPPER_COUNT  8'h14

// ----------------------------------------------------------------------------
// Timer control fields
// ----------------------------------------------------------------------------
`define TBIT_RUN    15
`define TBIT_IDLE   13
`define TBIT_GATE   6
`define TBIT_DIV_HI 5
`define TBIT_DIV_LO 4
`define TBIT_PAIR   3
`define TBIT_SRC    1

// ----------------------------------------------------------------------------
// Capture control fields
// ----------------------------------------------------------------------------
`define CBIT_IDLE   13
`define CBIT_TSEL   7
`define CBIT_IRQ_HI 6
`define CBIT_IRQ_LO 5
`define CBIT_OVF    4
`define CBIT_BNE    3
`define CBIT_MODE_HI 2

// ----------------------------------------------------------------------------
// Reset values and prescale terminal counts
// ----------------------------------------------------------------------------
`define RESET_WORD  16'h0000
`define DIV_LIM_1   8'h00
`define DIV_LIM_8   8'h07
`define DIV_LIM_64  8'h3F
`define DIV_LIM_256 8'hFF
`define COUNT_MAX   16'hFFFF

`endif

/* common/timer_pair_input_capture_pkg.sv */
// Types shared by the timer pair and input capture block.
// Assumes the constants header is included by the design file.
package timer_pair_input_capture_pkg;

   // Timer control as held in the control registers
   typedef struct packed {
      logic       timer_run_enable;
      logic       timer_idle_halt;
      logic       gate_accumulate_enable;
      logic [1:0] clock_divide_select;
      logic       pair_mode_select;
      logic       clock_source_select;
   } timer_ctrl_type;

   // Capture event modes
   typedef enum logic [2:0] {
      CAP_OFF        = 3'b000,
      CAP_EVERY_EDGE = 3'b001,
      CAP_FALL       = 3'b010,
      CAP_RISE       = 3'b011,
      CAP_RISE_4     = 3'b100,
      CAP_RISE_16    = 3'b101,
      CAP_UNUSED     = 3'b110,
      CAP_WAKE_ONLY  = 3'b111
   } capture_mode_type;

   // Capture channel control
   typedef struct packed {
      logic             capture_idle_halt;
      logic             capture_timebase_select;
      logic [1:0]       captures_per_interrupt;
      capture_mode_type capture_mode_select;
   } capture_ctrl_type;

endpackage

/* testbench/pin_source.sv */
// Far-side model: drives the capture pin and the timer clock pins.
// Assumes the bench calls pulse from one process on a running clock.
`timescale 1ns/1ps
`default_nettype none
module pin_source (
   input  wire logic       clk_i,
   output logic            cap_pin_o,
   output logic [1:0]      tclk_pin_o
);
   // Pins idle low; only the lower timer pin is ever clocked
   initial begin
      cap_pin_o  = 1'b0;
      tclk_pin_o = 2'b00;
   end
   // Ten-cycle period, each level held well beyond the filter length
   // Ext set drives the lower timer clock pin instead of the capture pin
   task automatic pulse(input int n, input bit ext = 1'b0);
      for (int k = 0; k < n; k++) begin
         @(posedge clk_i);
         if (ext) tclk_pin_o[0] <= 1'b1;
         else cap_pin_o <= 1'b1;
         repeat (5) @(posedge clk_i);
         if (ext) tclk_pin_o[0] <= 1'b0;
         else cap_pin_o <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the timer pair and capture channel.
// Assumes the defs header is on the include path.
`include "timer_pair_input_capture_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {logic [2:0] mode; logic [4:0] pulses; logic bne;} row_type;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, wake, trig, cap, er, idle, sleep;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  tclk;
   logic [15:0] v [4];
   int          mismatches = 0, check_count = 0, cycles = 0, irqs = 0, wakes = 0, trigs = 0, irq_base;
   row_type     rows [8] = '{'{3'b011, 5'd1, 1'b1}, '{3'b100, 5'd3, 1'b0}, '{3'b100, 5'd4, 1'b1},
      '{3'b101, 5'd16, 1'b1}, '{3'b000, 5'd2, 1'b0}, '{3'b110, 5'd2, 1'b0}, '{3'b010, 5'd1, 1'b1},
      '{3'b001, 5'd1, 1'b1}};
   timer_pair_input_capture timer_pair_input_capture_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .EXTERNAL_TIMER_CLOCK_PIN_I(tclk), .CAPTURE_INPUT_PIN_I(cap),
      .IDLE_I(idle), .SLEEP_I(sleep), .CAPTURE_IRQ_O(irq), .WAKE_O(wake), .ADC_TRIGGER_O(trig));
   pin_source pin_source_i (.clk_i(clk), .cap_pin_o(cap), .tclk_pin_o(tclk));
   // ----------------------------------------------------------------
   // Clock, timeout and interrupt tally
   // ----------------------------------------------------------------
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (irq === 1'b1) irqs <= irqs + 1;
      if (wake === 1'b1) wakes <= wakes + 1;
      if (trig === 1'b1) trigs <= trigs + 1;
      if (cycles == 5000) begin
         mismatches++;
         complete_run();
      end
   end
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; waits for ready without assuming a latency
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Ready, data and error all taken at the completing rising edge
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; idle = 0; sleep = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `ADDR_CAPTURE_CTRL, 32'h0000_0000);
      chk("ctrl_reset", rd, 32'h0000_0000);
      apb(1'b1, `ADDR_LOWER_CTRL, 32'h0000_8000);
      // Mode table: flush, select mode, pulse, look at buffer status
      foreach (rows[i]) begin
         apb(1'b1, `ADDR_CAPTURE_CTRL, 32'h0000_0000);
         apb(1'b1, `ADDR_CAPTURE_CTRL, {29'h0, rows[i].mode});
         pin_source_i.pulse(rows[i].pulses);
         repeat (8) @(posedge clk);
         apb(1'b0, `ADDR_CAPTURE_CTRL, 32'h0000_0000);
         chk("buffer_has_data", {31'h0, rd[3]}, {31'h0, rows[i].bne});
      end
      // Five captures into four entries: overflow, order, interrupt
      apb(1'b1, `ADDR_CAPTURE_CTRL, 32'h0000_0000);
      irq_base = irqs;
      apb(1'b1, `ADDR_CAPTURE_CTRL, 32'h0000_00E3);
      pin_source_i.pulse(5);
      repeat (8) @(posedge clk);
      apb(1'b0, `ADDR_CAPTURE_CTRL, 32'h0000_0000);
      chk("ovf_bne", rd & 32'h0000_0018, 32'h0000_0018);
      chk("irq_count", 32'(irqs - irq_base), 32'h0000_0001);
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, `ADDR_CAPTURE_BUF, 32'h0000_0000);
         v[k] = rd[15:0];
      end
      for (int k = 0; k < 3; k++) chk("spacing", {16'h0, v[k+1] - v[k]}, 32'h0000_000A);
      apb(1'b0, `ADDR_CAPTURE_CTRL, 32'h0000_0000);
      chk("drained", rd & 32'h0000_0008, 32'h0000_0000);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("slverr", {31'h0, er}, 32'h0000_0001);
      // Pair rollover; upper idle-halt stays clear
      apb(1'b1, `ADDR_LOWER_COUNT, 32'h0000_FFF0);
      apb(1'b1, `ADDR_UPPER_COUNT, 32'h0000_FFFF);
      apb(1'b1, `ADDR_LOWER_CTRL, 32'h0000_8008);
      repeat (20) @(posedge clk);
      chk("trigger_count", 32'(trigs), 32'h0000_0001);
      apb(1'b0, `ADDR_UPPER_COUNT, 32'h0000_0000);
      chk("upper_wrapped", rd, 32'h0000_0000);
      // Wake-only mode while asleep: pulses, no capture
      sleep <= 1'b1;
      apb(1'b1, `ADDR_CAPTURE_CTRL, 32'h0000_0007);
      irq_base = irqs;
      pin_source_i.pulse(1);
      repeat (8) @(posedge clk);
      chk("wake_count", 32'(wakes), 32'h0000_0001);
      chk("wake_irq", 32'(irqs - irq_base), 32'h0000_0001);
      apb(1'b0, `ADDR_CAPTURE_CTRL, 32'h0000_0000);
      chk("wake_no_capture", rd & 32'h0000_0008, 32'h0000_0000);
      sleep <= 1'b0;
      // Idle with the halt bit set freezes the lower count
      idle <= 1'b1;
      apb(1'b1, `ADDR_LOWER_CTRL, 32'h0000_A000);
      apb(1'b0, `ADDR_LOWER_COUNT, 32'h0000_0000);
      v[0] = rd[15:0];
      apb(1'b0, `ADDR_LOWER_COUNT, 32'h0000_0000);
      chk("idle_halt", rd, {16'h0, v[0]});
      // External pin clock; halt bit clear, so Idle does not stop it
      apb(1'b1, `ADDR_LOWER_CTRL, 32'h0000_8002);
      apb(1'b1, `ADDR_LOWER_COUNT, 32'h0000_0000);
      pin_source_i.pulse(5, 1'b1);
      repeat (8) @(posedge clk);
      apb(1'b0, `ADDR_LOWER_COUNT, 32'h0000_0000);
      chk("ext_count", rd, 32'h0000_0005);
      complete_run();
   end
endmodule
`default_nettype wire
